//--- hdl/feed_pkg.sv
// Constants shared by the paper feed motor and sensor logic.
package feed_pkg;
	// Clock rate in kHz, used to turn times into cycle counts.
	localparam int CLK_KHZ = 250000;
	// Distance per step in micrometres.
	localparam int STEP_UM = 130;
	// Default step period in microseconds and its cycle count.
	localparam int STEP_PERIOD_US = 2000;
	localparam int STEP_PERIOD_CYC = STEP_PERIOD_US * CLK_KHZ / 1000;
	// Settle time of the shared sensor input, in microseconds.
	localparam int SETTLE_US = 20;
	localparam int SETTLE_CYC = SETTLE_US * CLK_KHZ / 1000;
	// Width of the step count and distance inputs.
	localparam int COUNT_W = 16;
	// Two-phase excitation patterns, coil order a, b, a_n, b_n.
	localparam logic [3:0] PHASE0 = 4'h3;
	localparam logic [3:0] PHASE1 = 4'h6;
	localparam logic [3:0] PHASE2 = 4'hc;
	localparam logic [3:0] PHASE3 = 4'h9;
	localparam logic [1:0] PHASE_RESET = 2'h0;
endpackage

//--- hdl/step_channel.sv
// One stepping motor channel: run control, step rate and phase pattern.
`timescale 1ns/1ps
module step_channel #(
	parameter int PERIOD_CYC = feed_pkg::STEP_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic stop,
	input wire logic [feed_pkg::COUNT_W-1:0] steps,
	output logic power_en,
	output logic [3:0] phase,
	output logic step_pulse,
	output logic busy,
	output logic done
);
	localparam int CW = $clog2(PERIOD_CYC + 1);
	// A period under two cycles would merge step pulses into a level.
	if (PERIOD_CYC < 2) begin : g_period_check
		$error("step period too short");
	end
	logic [CW-1:0] tick_reg;
	logic [feed_pkg::COUNT_W-1:0] left_reg;
	logic [1:0] idx_reg;
	logic tick;
	assign tick = busy && (tick_reg == CW'(PERIOD_CYC - 1));

	// Step rate divider runs only while the motor is driven.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_reg <= '0;
		end else if (!busy || tick) begin
			tick_reg <= '0;
		end else begin
			tick_reg <= tick_reg + 1'b1;
		end
	end

	// Run state; power enable follows it so the coil sees full drive.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			power_en <= 1'b0;
			left_reg <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (stop) begin
				busy <= 1'b0;
				power_en <= 1'b0;
			end else if (!busy && start && steps != '0) begin
				busy <= 1'b1;
				power_en <= 1'b1;
				left_reg <= steps;
			end else if (tick) begin
				left_reg <= left_reg - 1'b1;
				if (left_reg == 1) begin
					busy <= 1'b0;
					power_en <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	// Pattern index advances one state per step; held when stopped.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idx_reg <= feed_pkg::PHASE_RESET;
			step_pulse <= 1'b0;
		end else begin
			step_pulse <= tick;
			if (tick) begin
				idx_reg <= idx_reg + 2'h1;
			end
		end
	end

	// Two coils energised at once in every state.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase <= feed_pkg::PHASE0;
		end else begin
			unique case (idx_reg)
				2'h0: phase <= feed_pkg::PHASE0;
				2'h1: phase <= feed_pkg::PHASE1;
				2'h2: phase <= feed_pkg::PHASE2;
				2'h3: phase <= feed_pkg::PHASE3;
			endcase
		end
	end
endmodule

//--- hdl/feed_ctrl.sv
// Paper feed top: two motor channels and the paper-path sensor decode.
`timescale 1ns/1ps
module feed_ctrl #(
	parameter int PERIOD_CYC = feed_pkg::STEP_PERIOD_CYC,
	parameter int SETTLE_CYC = feed_pkg::SETTLE_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic doc_start,
	input wire logic doc_stop,
	input wire logic [feed_pkg::COUNT_W-1:0] doc_um,
	input wire logic rec_start,
	input wire logic rec_stop,
	input wire logic [feed_pkg::COUNT_W-1:0] rec_um,
	input wire logic paper_n,
	input wire logic jam_n,
	input wire logic cover_n,
	input wire logic shared_in,
	output logic doc_power_en,
	output logic [3:0] doc_phase,
	output logic doc_step,
	output logic doc_busy,
	output logic doc_done,
	output logic rec_power_en,
	output logic [3:0] rec_phase,
	output logic rec_step,
	output logic rec_busy,
	output logic rec_done,
	output logic read_sel_n,
	output logic set_sel_n,
	output logic paper_present,
	output logic paper_jam,
	output logic cover_closed,
	output logic doc_at_read,
	output logic doc_loaded
);
	localparam int SW = $clog2(SETTLE_CYC + 1);
	// The select register and two sync stages need four cycles before a
	// sample is valid, so shorter settle windows would read a stale line.
	if (SETTLE_CYC < 4) begin : g_settle_check
		$error("settle time too short");
	end

	////////////////////////////////////////////////////////////////////////
	// Distance to steps, rounded up so paper never stops short.
	function automatic logic [feed_pkg::COUNT_W-1:0] to_steps(
		input logic [feed_pkg::COUNT_W-1:0] um);
		logic [feed_pkg::COUNT_W:0] s;
		s = ({1'b0, um} + (feed_pkg::COUNT_W+1)'(feed_pkg::STEP_UM - 1))
			/ (feed_pkg::COUNT_W+1)'(feed_pkg::STEP_UM);
		return s[feed_pkg::COUNT_W-1:0];
	endfunction

	// Document feed motor for reading, own enable and steps.
	step_channel #(.PERIOD_CYC(PERIOD_CYC)) doc_motor (
		.clk(clk),
		.reset(reset),
		.start(doc_start),
		.stop(doc_stop),
		.steps(to_steps(doc_um)),
		.power_en(doc_power_en),
		.phase(doc_phase),
		.step_pulse(doc_step),
		.busy(doc_busy),
		.done(doc_done)
	);

	// Recording paper motor for printing.
	step_channel #(.PERIOD_CYC(PERIOD_CYC)) rec_motor (
		.clk(clk),
		.reset(reset),
		.start(rec_start),
		.stop(rec_stop),
		.steps(to_steps(rec_um)),
		.power_en(rec_power_en),
		.phase(rec_phase),
		.step_pulse(rec_step),
		.busy(rec_busy),
		.done(rec_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin inputs pass two flip-flops; only stage two is read.
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= 4'hf;
			sync2_reg <= 4'hf;
		end else begin
			sync1_reg <= {shared_in, cover_n, jam_n, paper_n};
			sync2_reg <= sync1_reg;
		end
	end

	// Direct sensors, all active low at the pin.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			paper_present <= 1'b0;
			paper_jam <= 1'b0;
			cover_closed <= 1'b0;
		end else begin
			paper_present <= !sync2_reg[0];
			paper_jam <= !sync2_reg[1];
			cover_closed <= !sync2_reg[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared input poller: alternate selects with a gap and settle wait.
	typedef enum logic [1:0] {READ_SEL, SET_SEL, GAP_TO_SET, GAP_TO_READ}
		poll_e;
	poll_e poll_reg;
	logic [SW-1:0] wait_reg;
	logic settled;
	assign settled = (wait_reg == SW'(SETTLE_CYC - 1));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			poll_reg <= GAP_TO_READ;
			wait_reg <= '0;
		end else if (!settled) begin
			wait_reg <= wait_reg + 1'b1;
		end else begin
			wait_reg <= '0;
			unique case (poll_reg)
				READ_SEL: poll_reg <= GAP_TO_SET;
				GAP_TO_SET: poll_reg <= SET_SEL;
				SET_SEL: poll_reg <= GAP_TO_READ;
				GAP_TO_READ: poll_reg <= READ_SEL;
			endcase
		end
	end

	// At most one select low; the gap states deselect both.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			read_sel_n <= 1'b1;
			set_sel_n <= 1'b1;
		end else begin
			read_sel_n <= !(poll_reg == READ_SEL);
			set_sel_n <= !(poll_reg == SET_SEL);
		end
	end

	// Sample at the end of a settled select window only.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			doc_at_read <= 1'b0;
			doc_loaded <= 1'b0;
		end else if (settled) begin
			if (poll_reg == READ_SEL) begin
				doc_at_read <= !sync2_reg[3];
			end
			if (poll_reg == SET_SEL) begin
				doc_loaded <= sync2_reg[3];
			end
		end
	end
endmodule

//--- verif/feed_partner.sv
// Far-side model: switch sensors sharing one input line.
`timescale 1ns/1ps
module feed_partner (
	input wire logic clk,
	input wire logic read_sel_n,
	input wire logic set_sel_n,
	input wire logic rd_lvl,
	input wire logic set_lvl,
	output logic shared_in
);
	logic last = 1'b0;
	// An unselected line floats, so show the inverse of the last level.
	always @* begin
		if (!read_sel_n)
			shared_in = rd_lvl;
		else if (!set_sel_n)
			shared_in = set_lvl;
		else
			shared_in = ~last;
	end
	// Remember the level last driven by a selected sensor.
	always @(posedge clk) begin
		if (!read_sel_n || !set_sel_n)
			last <= shared_in;
	end
endmodule

//--- verif/feed_monitor.sv
// Checker watching the ports of the paper feed top.
`timescale 1ns/1ps
module feed_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic doc_start,
	input wire logic doc_stop,
	input wire logic [feed_pkg::COUNT_W-1:0] doc_um,
	input wire logic doc_power_en,
	input wire logic [3:0] doc_phase,
	input wire logic doc_step,
	input wire logic doc_busy,
	input wire logic rec_power_en,
	input wire logic rec_busy,
	input wire logic read_sel_n,
	input wire logic set_sel_n,
	input wire logic paper_n,
	input wire logic jam_n,
	input wire logic paper_present,
	input wire logic paper_jam
);
	logic [3:0] ph_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Phase seen at the step pulse, to check the advance after it.
	always_ff @(posedge clk) begin
		ph_reg <= doc_phase;
	end
	sequence s_go;
		doc_start && !doc_stop && !doc_busy && doc_um != 16'h0;
	endsequence
	sequence s_step;
		doc_step;
	endsequence
	//////////////////////////////
	chk_start_run: assert property (s_go |=> doc_busy && doc_power_en)
		else $error("feed did not start");
	chk_stop_drop: assert property (doc_stop |=> !doc_power_en)
		else $error("stop left enable high");
	chk_enable_busy: assert property (
		doc_power_en == doc_busy && rec_power_en == rec_busy)
		else $error("enable differs from busy");
	chk_phase_step: assert property (
		s_step |=> doc_phase == {ph_reg[2:0], ph_reg[3]})
		else $error("phase did not advance");
	chk_phase_hold: assert property (!doc_step |=> $stable(doc_phase))
		else $error("phase moved without step");
	chk_two_coils: assert property ($countones(doc_phase) == 2)
		else $error("not two coils energised");
	// Gap assumes the bench period of eight cycles.
	chk_step_gap: assert property (s_step |=> !doc_step [*7])
		else $error("steps too close");
	chk_sel_one: assert property (read_sel_n || set_sel_n)
		else $error("both selects low");
	chk_paper_low: assert property (!paper_n [*4] |-> paper_present)
		else $error("paper not seen");
	chk_jam_low: assert property (!jam_n [*4] |-> paper_jam)
		else $error("jam not seen");
endmodule
bind feed_ctrl feed_monitor i_feed_monitor (.*);

//--- verif/tb.sv
// Self-checking bench for the paper feed top.
`timescale 1ns/1ps
module tb;
	logic clk = 0, reset = 1, doc_start = 0, doc_stop = 0;
	logic rec_start = 0, rec_stop = 0, rd_lvl = 1, set_lvl = 1;
	logic paper_n = 1, jam_n = 1, cover_n = 1, shared_in;
	logic [15:0] doc_um = 16'h0, rec_um = 16'h0;
	logic doc_power_en, doc_step, doc_busy, doc_done, rec_power_en;
	logic rec_step, rec_busy, rec_done, read_sel_n, set_sel_n;
	logic paper_present, paper_jam, cover_closed, doc_at_read, doc_loaded;
	logic [3:0] doc_phase, rec_phase, dph = 4'h3, rph = 4'h3;
	int errors = 0, comparisons = 0, cyc = 0, dn = 0, rn = 0;
	int dd = 0, rd = 0;
	feed_ctrl #(.PERIOD_CYC(8), .SETTLE_CYC(4)) i_feed_ctrl (.*);
	feed_partner i_feed_partner (.*);
	initial forever #2 clk = ~clk;
	//////////////////////////////
	task chk(input logic [15:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Count steps; the cycle ceiling cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (doc_step === 1'b1) dn <= dn + 1;
		if (rec_step === 1'b1) rn <= rn + 1;
		if (doc_done === 1'b1) dd <= dd + 1;
		if (rec_done === 1'b1) rd <= rd + 1;
		if (cyc == 6000) begin
			errors++;
			report_and_stop();
		end
	end
	// Expected step count: distance rounded up to whole steps.
	function automatic int exp_steps(input int um);
		return (um + feed_pkg::STEP_UM - 1) / feed_pkg::STEP_UM;
	endfunction
	// Expected coil pattern after n forward steps starting from p.
	function automatic logic [3:0] exp_phase(input logic [3:0] p,
		input int n);
		for (int i = 0; i < n; i++) p = {p[2:0], p[3]};
		return p;
	endfunction
	// Run both motors together; distances round up to whole steps.
	task feed(input logic [15:0] du, ru);
		int ds, rs;
		ds = exp_steps(du);
		rs = exp_steps(ru);
		@(posedge clk);
		dn <= 0;
		rn <= 0;
		dd <= 0;
		rd <= 0;
		doc_um <= du;
		rec_um <= ru;
		doc_start <= 1;
		rec_start <= 1;
		@(posedge clk);
		doc_start <= 0;
		rec_start <= 0;
		@(posedge clk);
		#1;
		chk(doc_power_en, ds != 0, "doc enable");
		chk(rec_power_en, rs != 0, "rec enable");
		// Busy is read before the edge updates it, so one more edge
		// passes after the last step; that keeps the last pulse counted.
		repeat (200) begin
			if (doc_busy === 1'b1 || rec_busy === 1'b1) @(posedge clk);
		end
		@(posedge clk);
		#1;
		chk(dn, ds, "doc steps");
		chk(rn, rs, "rec steps");
		chk(dd, ds != 0, "doc done");
		chk(rd, rs != 0, "rec done");
		dph = exp_phase(dph, ds);
		rph = exp_phase(rph, rs);
		chk(doc_phase, dph, "doc phase");
		chk(rec_phase, rph, "rec phase");
		chk(doc_power_en, 0, "doc off");
		chk(rec_power_en, 0, "rec off");
		$display("feed test done %0d %0d", du, ru);
	endtask
	// Main sequence: reset, feeds, stop, sensors.
	initial begin
		void'($urandom(79));
		repeat (11) @(posedge clk);
		#1;
		chk(doc_phase, 4'h3, "reset phase");
		chk({read_sel_n, set_sel_n}, 2'h3, "reset sel");
		chk(doc_power_en, 0, "reset enable");
		$display("reset test done");
		// Twelfth edge with reset high, then release on the edge.
		@(posedge clk);
		reset <= 0;
		feed(16'h0082, 16'h0083);
		feed(16'h0000, 16'h0410);
		for (int i = 0; i < 5; i++)
			feed(16'($urandom_range(1040, 1)), 16'($urandom_range(1040, 1)));
		@(posedge clk);
		doc_um <= 16'h0410;
		doc_start <= 1;
		@(posedge clk);
		doc_start <= 0;
		repeat (20) @(posedge clk);
		doc_stop <= 1;
		@(posedge clk);
		doc_stop <= 0;
		@(posedge clk);
		#1;
		chk(doc_power_en, 0, "stop");
		$display("stop test done");
		// Reset in mid-run drops the drive and returns the pattern home.
		@(posedge clk);
		doc_start <= 1;
		@(posedge clk);
		doc_start <= 0;
		repeat (20) @(posedge clk);
		reset <= 1;
		@(posedge clk);
		reset <= 0;
		#1;
		chk(doc_power_en, 0, "reset drop");
		chk(doc_phase, 4'h3, "reset home");
		dph = 4'h3;
		$display("mid-run reset test done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{paper_n, jam_n, cover_n, rd_lvl, set_lvl} <= 5'(i ? $urandom : 0);
			repeat (40) @(posedge clk);
			#1;
			chk(paper_present, !paper_n, "paper");
			chk(paper_jam, !jam_n, "jam");
			chk(cover_closed, !cover_n, "cover");
			chk(doc_at_read, !rd_lvl, "read pos");
			chk(doc_loaded, set_lvl, "doc set");
		end
		$display("sensor test done");
		report_and_stop();
	end
endmodule
